// file: logic/i2c_port_defines.svh
// Register offsets, reset values, masks and widths of the I2C register port.
`ifndef I2C_PORT_DEFINES_SVH
`define I2C_PORT_DEFINES_SVH

`define ADDR_W        11
`define NUM_REGS      7
`define BIT_CNT_BYTE  4'h8
`define CTRL_CODE_RST 4'h3
`define BLK_MAPPED    3'h0

`define REG_LED3      8'hc2
`define REG_LED4      8'hc4
`define REG_LED1_LO   8'hc5
`define REG_LED1_HI   8'hc6
`define REG_LED2_LO   8'hc7
`define REG_LED2_HI   8'hc8
`define REG_SWITCH    8'hf4

`define PWM_RST       8'h65
`define PWM_HI_RST    8'h00
`define SWITCH_RST    8'h00
`define SWITCH_MASK   8'h03
`define FULL_MASK     8'hff
`define UNMAPPED_RD   8'h00

`endif

// file: logic/i2c_port_pkg.sv
// Types shared by the I2C register port and its register bank.
package i2c_port_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CTRL, ST_CTRL_ACK, ST_WADDR, ST_WADDR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK, ST_IGNORE
  } state_e;

  typedef struct packed {
    logic        en;
    logic [10:0] addr;
    byte_t       data;
  } wr_req_s;

  typedef struct packed {
    logic [15:0] led1;
    logic [15:0] led2;
    byte_t       led3;
    byte_t       led4;
    logic [1:0]  sw_en;
  } led_cfg_s;

endpackage

// file: logic/reg_bank.sv
// Register bank holding the LED PWM compare bytes and the virtual switch byte.
`timescale 1ns/1ps
`include "i2c_port_defines.svh"

module reg_bank #(
  parameter int ADDR_W = `ADDR_W
) (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   ce,
  input  wire i2c_port_pkg::wr_req_s  wr,
  input  wire logic [ADDR_W-1:0]      rd_addr,
  output i2c_port_pkg::byte_t         rd_data,
  output i2c_port_pkg::led_cfg_s      cfg
);
  import i2c_port_pkg::*;

  localparam byte_t REG_ADDR [`NUM_REGS] = '{`REG_LED3, `REG_LED4, `REG_LED1_LO, `REG_LED1_HI,
                                             `REG_LED2_LO, `REG_LED2_HI, `REG_SWITCH};
  localparam byte_t REG_RST  [`NUM_REGS] = '{`PWM_RST, `PWM_RST, `PWM_RST, `PWM_HI_RST,
                                             `PWM_RST, `PWM_HI_RST, `SWITCH_RST};
  localparam byte_t REG_MASK [`NUM_REGS] = '{`FULL_MASK, `FULL_MASK, `FULL_MASK, `FULL_MASK,
                                             `FULL_MASK, `FULL_MASK, `SWITCH_MASK};

  logic [`NUM_REGS-1:0][7:0] regs;
  byte_t                     rd_sel;

  // ****************************************
  // Storage, one byte per mapped offset.
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < `NUM_REGS; g++) begin : g_reg
      byte_t q_r;
      always_ff @(posedge clk) begin
        if (!nrst) begin
          q_r <= REG_RST[g]; // R13 R14 R15 R16 R11 R12
        end else if (ce && wr.en && wr.addr == {`BLK_MAPPED, REG_ADDR[g]}) begin
          q_r <= wr.data & REG_MASK[g]; // R8
        end
      end
      assign regs[g] = q_r;
    end
  endgenerate

  // Unmapped offsets read as zero so a stray read never floats the bus.
  always_comb begin
    rd_sel = `UNMAPPED_RD;
    for (int i = 0; i < `NUM_REGS; i++) begin
      if (rd_addr == {`BLK_MAPPED, REG_ADDR[i]}) begin
        rd_sel = regs[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_data <= `UNMAPPED_RD;
    end else if (ce) begin
      rd_data <= rd_sel;
    end
  end

  assign cfg.led3  = regs[0]; // R15
  assign cfg.led4  = regs[1]; // R16
  assign cfg.led1  = {regs[3], regs[2]}; // R13
  assign cfg.led2  = {regs[5], regs[4]}; // R14
  assign cfg.sw_en = ~regs[6][1:0]; // R11 R12

  // ****************************************
  // Assertions.
  // ****************************************
  a_pwm_defaults: assert property ( // R13 R14 R15 R16
    @(posedge clk) !nrst |=> cfg.led1[7:0] == `PWM_RST && cfg.led2[7:0] == `PWM_RST
      && cfg.led3 == `PWM_RST && cfg.led4 == `PWM_RST && cfg.sw_en == 2'b11)
    else $error("PWM or switch byte not at its reset value");

  a_switch_write: assert property ( // R11 R12
    @(posedge clk) disable iff (!nrst || !ce)
    wr.en && wr.addr == {`BLK_MAPPED, `REG_SWITCH} |=> cfg.sw_en == ~$past(wr.data[1:0]))
    else $error("Switch enable does not follow the written bits");

endmodule

// file: logic/i2c_led_pwm_register_port.sv
// I2C target port giving access to the LED PWM and virtual switch registers.
// Overview of operation
// R1: Control byte opens with configurable 4-bit code.
// R2: Next three bits are block address bits.
// R3: Last control bit: one reads, zero writes.
// R4: Device acknowledges every accepted control byte.
// R5: Master sends word address except current read.
// R6: Pointer loads block bits plus word address.
// R7: Byte write: data, acknowledge, then Stop.
// R8: Data byte commits when its acknowledge is driven.
// R9: Repeated Start ends write, keeps the pointer.
// R10: Read control byte acknowledged, eight bits shifted out.
// R11: Offset F4 bit zero disables switch zero.
// R12: Offset F4 bit one disables switch one.
// R13: Offsets C5/C6 hold LED1 compare, 0x65 default.
// R14: Offsets C7/C8 hold LED2 compare, 0x65 default.
// R15: Offset C2 holds LED3 compare, 0x65 default.
// R16: Offset C4 holds LED4 compare, 0x65 default.
// R17: Current address read returns byte at pointer.
// R18: Wrong control code is ignored, no acknowledge.
`timescale 1ns/1ps
`include "i2c_port_defines.svh"

module i2c_led_pwm_register_port #(
  parameter int ADDR_W = `ADDR_W
) (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   ce,
  input  wire logic [3:0]             cfg_ctrl_code,
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe_n,
  output i2c_port_pkg::led_cfg_s      led_cfg,
  output logic                        switch_output_zero,
  output logic                        switch_output_one
);
  import i2c_port_pkg::*;

  // ****************************************
  // Pin synchronisers and bus events.
  // ****************************************
  logic [1:0]         scl_sync_r;
  logic [1:0]         sda_sync_r;
  logic               scl_d_r;
  logic               sda_d_r;
  logic               scl_s;
  logic               sda_s;
  logic               scl_rise;
  logic               scl_fall;
  logic               start_det;
  logic               stop_det;

  state_e             state_r;
  state_e             state_nxt;
  logic [3:0]         bit_cnt_r;
  byte_t              shift_in_r;
  byte_t              shift_out_r;
  byte_t              shift_out_nxt;
  logic               rw_r;
  logic [2:0]         blk_r;
  logic [ADDR_W-1:0]  ptr_r;
  logic               ack_clk_r;
  logic               master_ack_r;
  logic               sda_oe_n_r;
  wr_req_s            wr_r;
  byte_t              rd_data;
  logic               byte_done;
  logic               ack_done;
  logic               code_ok;
  logic               entering;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      scl_sync_r <= 2'b11;
      sda_sync_r <= 2'b11;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end else if (ce) begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      scl_d_r    <= scl_sync_r[1];
      sda_d_r    <= sda_sync_r[1];
    end
  end

  assign scl_s     = scl_sync_r[1];
  assign sda_s     = sda_sync_r[1];
  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // A byte ends on the falling edge that follows its eighth rising edge.
  assign byte_done = scl_fall && bit_cnt_r == `BIT_CNT_BYTE;
  assign ack_done  = scl_fall && ack_clk_r;
  assign code_ok   = shift_in_r[7:4] == cfg_ctrl_code; // R1
  assign entering  = state_nxt != state_r;

  // ****************************************
  // Transaction sequencer.
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    if (stop_det) begin
      state_nxt = ST_IDLE;
    end else if (start_det) begin
      state_nxt = ST_CTRL; // R9
    end else begin
      unique case (state_r)
        ST_IDLE, ST_IGNORE: begin
          state_nxt = state_r;
        end
        ST_CTRL: begin
          if (byte_done) begin
            state_nxt = code_ok ? ST_CTRL_ACK : ST_IGNORE; // R18
          end
        end
        ST_CTRL_ACK: begin
          if (ack_done) begin
            state_nxt = rw_r ? ST_RDATA : ST_WADDR; // R3 R5 R17
          end
        end
        ST_WADDR: begin
          if (byte_done) begin
            state_nxt = ST_WADDR_ACK;
          end
        end
        ST_WADDR_ACK: begin
          if (ack_done) begin
            state_nxt = ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (byte_done) begin
            state_nxt = ST_WDATA_ACK; // R7
          end
        end
        ST_WDATA_ACK: begin
          if (ack_done) begin
            state_nxt = ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (byte_done) begin
            state_nxt = ST_RACK;
          end
        end
        ST_RACK: begin
          if (ack_done) begin
            state_nxt = master_ack_r ? ST_RDATA : ST_IGNORE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // Bits and the ninth clock are counted afresh in every phase.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bit_cnt_r <= 4'h0;
      ack_clk_r <= 1'b0;
    end else if (ce) begin
      if (entering) begin
        bit_cnt_r <= 4'h0;
        ack_clk_r <= 1'b0;
      end else if (scl_rise) begin
        bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
        ack_clk_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      shift_in_r   <= 8'h00;
      master_ack_r <= 1'b0;
    end else if (ce && scl_rise) begin
      shift_in_r   <= {shift_in_r[6:0], sda_s};
      master_ack_r <= ~sda_s;
    end
  end

  // ****************************************
  // Control byte fields and address pointer.
  // ****************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rw_r  <= 1'b0;
      blk_r <= 3'h0;
    end else if (ce && state_r == ST_CTRL && byte_done) begin
      rw_r <= shift_in_r[0]; // R3
      if (!shift_in_r[0]) begin
        blk_r <= shift_in_r[3:1]; // R2
      end
    end
  end

  // A Start never touches the pointer, so a random read finds it loaded.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ptr_r <= '0;
    end else if (ce) begin
      if (state_r == ST_WADDR && byte_done) begin
        ptr_r <= {blk_r, shift_in_r}; // R6
      end else if ((state_r == ST_WDATA || state_r == ST_RDATA) && byte_done) begin
        ptr_r <= ptr_r + 11'h001;
      end
    end
  end

  // The write goes out in the cycle the acknowledge starts to drive.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_r <= '0;
    end else if (ce) begin
      wr_r.en   <= state_r == ST_WDATA && byte_done; // R8
      wr_r.addr <= ptr_r;
      wr_r.data <= shift_in_r;
    end
  end

  // ****************************************
  // Data out and acknowledge driver.
  // ****************************************
  always_comb begin
    shift_out_nxt = shift_out_r;
    if (state_nxt == ST_RDATA && entering) begin
      shift_out_nxt = rd_data; // R10 R17
    end else if (state_r == ST_RDATA && scl_fall) begin
      shift_out_nxt = {shift_out_r[6:0], 1'b1};
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      shift_out_r <= 8'hff;
    end else if (ce) begin
      shift_out_r <= shift_out_nxt;
    end
  end

  // Changes follow state changes and read data shifts, which only happen on falling SCL or Start/Stop.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sda_oe_n_r <= 1'b1;
    end else if (ce) begin
      unique case (state_nxt)
        ST_CTRL_ACK, ST_WADDR_ACK, ST_WDATA_ACK: begin
          sda_oe_n_r <= 1'b0; // R4 R7
        end
        ST_RDATA: begin
          sda_oe_n_r <= shift_out_nxt[7]; // R10
        end
        default: begin
          sda_oe_n_r <= 1'b1; // R18
        end
      endcase
    end
  end

  assign sda_oe_n = sda_oe_n_r;
  assign sda_out  = 1'b0;

  // ****************************************
  // Register bank.
  // ****************************************
  reg_bank #(
    .ADDR_W (ADDR_W)
  ) u_bank (
    .clk     (clk),
    .nrst    (nrst),
    .ce      (ce),
    .wr      (wr_r),
    .rd_addr (ptr_r),
    .rd_data (rd_data),
    .cfg     (led_cfg)
  );

  assign switch_output_zero = led_cfg.sw_en[0]; // R11
  assign switch_output_one  = led_cfg.sw_en[1]; // R12

  // ****************************************
  // Assertions.
  // ****************************************
  sequence s_ctrl_ok;
    state_r == ST_CTRL && byte_done && code_ok;
  endsequence
  sequence s_data_in;
    state_r == ST_WDATA && byte_done;
  endsequence
  sequence s_read_go;
    state_r == ST_CTRL_ACK && ack_done && rw_r && !start_det && !stop_det;
  endsequence
  a_ctrl_ack: assert property ( // R4
    @(posedge clk) disable iff (!nrst || !ce)
    s_ctrl_ok |=> state_r == ST_CTRL_ACK && !sda_oe_n)
    else $error("Matching control byte not acknowledged");
  a_code_mismatch: assert property ( // R18
    @(posedge clk) disable iff (!nrst || !ce)
    state_r == ST_CTRL && byte_done && !code_ok |=> state_r == ST_IGNORE && sda_oe_n)
    else $error("Foreign control code not ignored");
  a_ignore_quiet: assert property ( // R18
    @(posedge clk) disable iff (!nrst || !ce)
    state_r == ST_IGNORE |-> sda_oe_n)
    else $error("Bus driven while ignoring a transaction");
  a_rw_latch: assert property ( // R3
    @(posedge clk) disable iff (!nrst || !ce)
    s_ctrl_ok |=> rw_r == $past(shift_in_r[0]) ##0 (rw_r || blk_r == $past(shift_in_r[3:1])))
    else $error("Direction or block bits not captured");
  a_ptr_load: assert property ( // R6
    @(posedge clk) disable iff (!nrst || !ce)
    state_r == ST_WADDR && byte_done |=> ptr_r == {blk_r, $past(shift_in_r)} && !sda_oe_n)
    else $error("Pointer not loaded from block and word address");
  a_write_commit: assert property ( // R8
    @(posedge clk) disable iff (!nrst || !ce)
    s_data_in |=> wr_r.en && !sda_oe_n && wr_r.data == $past(shift_in_r) ##1 !wr_r.en)
    else $error("Data byte not committed with its acknowledge");
  a_restart_keep: assert property ( // R9
    @(posedge clk) disable iff (!nrst || !ce)
    start_det && state_r != ST_IDLE |=> state_r == ST_CTRL && ptr_r == $past(ptr_r))
    else $error("Repeated Start lost the pointer or the framing");
  a_read_first: assert property ( // R10
    @(posedge clk) disable iff (!nrst || !ce)
    s_read_go |=> state_r == ST_RDATA && sda_oe_n == $past(rd_data[7]))
    else $error("First read bit does not match the addressed byte");
  a_read_release: assert property ( // R10
    @(posedge clk) disable iff (!nrst || !ce)
    state_r == ST_RDATA && byte_done && !start_det |=> state_r == ST_RACK && sda_oe_n)
    else $error("Bus not released for the master acknowledge");
endmodule

// file: tb/i2c_master_model.sv
// Behavioural I2C bus master that drives SCL and an open-drain SDA towards the register port.
`timescale 1ns/1ps

module i2c_master_model #(
  parameter int HALF = 10
) (
  input  wire logic clk,
  input  wire logic sda_bus,
  output logic      scl,
  output logic      sda_drv
);

  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  // Every pin change lands 1 ns after a clock edge.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // ****************************************
  // Bus conditions.
  // ****************************************

  // Also serves as the repeated Start that ends write decoding but keeps the pointer.
  task automatic start_cond();
    tick(3);
    sda_drv = 1'b1;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_drv = 1'b0;
    tick(HALF);
    scl = 1'b0;
  endtask

  // A byte write ends with Stop right after the data byte is acknowledged.
  task automatic stop_cond();
    tick(3);
    sda_drv = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_drv = 1'b1;
    tick(HALF);
  endtask

  // ****************************************
  // Bit and byte transfer.
  // ****************************************

  // SDA moves 3 cycles after SCL falls so that the synchronised pins never show a false Start or Stop.
  task automatic bit_xfer(input logic tx, output logic rx);
    tick(3);
    sda_drv = tx;
    tick(HALF - 3);
    scl = 1'b1;
    tick(HALF / 2);
    rx = sda_bus;
    tick(HALF / 2);
    scl = 1'b0;
  endtask

  // Sending 1 releases SDA to the pull-up, which is how the master reads data or the device ack.
  task automatic byte_xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(tx[i], rx[i]);
    end
    bit_xfer(ack_in, ack);
  endtask

endmodule

// file: tb/tb_i2c_led_pwm_register_port.sv
// Self-checking testbench of the I2C register port, driven through the bus master model.
`timescale 1ns/1ps
`include "i2c_port_defines.svh"

module tb_i2c_led_pwm_register_port;
  import i2c_port_pkg::*;

  logic       clk;
  logic       nrst;
  logic       ce;
  logic [3:0] cfg_ctrl_code;
  logic       scl;
  logic       sda_drv;
  logic       sda_out;
  logic       sda_oe_n;
  logic       sw0;
  logic       sw1;
  led_cfg_s   led_cfg;
  wire logic  sda_bus;
  int         error_cnt;
  int         num_checks;
  byte_t      d;
  logic       ack;

  byte_t reg_addr [7] = '{`REG_LED3, `REG_LED4, `REG_LED1_LO, `REG_LED1_HI, `REG_LED2_LO, `REG_LED2_HI, `REG_SWITCH};
  byte_t reg_rst  [7] = '{8'h65, 8'h65, 8'h65, 8'h00, 8'h65, 8'h00, 8'h00};
  byte_t wr_val   [7] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'hfe};
  byte_t rd_exp   [7] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h02};

  // SDA has a pull-up: it is low only while some party pulls it down.
  assign sda_bus = sda_drv & (sda_oe_n | sda_out);

  i2c_led_pwm_register_port dut (
    .clk                (clk),
    .nrst               (nrst),
    .ce                 (ce),
    .cfg_ctrl_code      (cfg_ctrl_code),
    .scl_in             (scl),
    .sda_in             (sda_bus),
    .sda_out            (sda_out),
    .sda_oe_n           (sda_oe_n),
    .led_cfg            (led_cfg),
    .switch_output_zero (sw0),
    .switch_output_one  (sw1)
  );

  i2c_master_model mst (
    .clk     (clk),
    .sda_bus (sda_bus),
    .scl     (scl),
    .sda_drv (sda_drv)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // Checking and closing.
  // ****************************************

  task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic close_out();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************
  // Register access over I2C.
  // ****************************************

  task automatic wr_reg(input logic [3:0] code, input logic [2:0] blk, input byte_t a, input byte_t v, input logic ea);
    byte_t rx;
    logic  k;
    mst.start_cond();
    mst.byte_xfer({code, blk, 1'b0}, 1'b1, rx, k);
    check_val("ctrl ack", {15'h0000, ea}, {15'h0000, k});
    mst.byte_xfer(a, 1'b1, rx, k);
    check_val("addr ack", {15'h0000, ea}, {15'h0000, k});
    mst.byte_xfer(v, 1'b1, rx, k);
    check_val("data ack", {15'h0000, ea}, {15'h0000, k});
    mst.stop_cond();
  endtask

  task automatic rd_reg(input byte_t a, output byte_t v);
    logic k;
    mst.start_cond();
    mst.byte_xfer({cfg_ctrl_code, 3'h0, 1'b0}, 1'b1, v, k);
    mst.byte_xfer(a, 1'b1, v, k);
    mst.start_cond();
    mst.byte_xfer({cfg_ctrl_code, 3'h0, 1'b1}, 1'b1, v, k);
    check_val("read ctrl ack", 16'h0000, {15'h0000, k});
    mst.byte_xfer(8'hff, 1'b1, v, k);
    mst.stop_cond();
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    close_out();
  end

  // ****************************************
  // Main sequence.
  // ****************************************

  initial begin
    nrst          = 1'b0;
    ce            = 1'b1;
    cfg_ctrl_code = `CTRL_CODE_RST;
    error_cnt     = 0;
    num_checks    = 0;
    repeat (16) @(posedge clk);
    #1;
    nrst = 1'b1;
    mst.tick(5);
    check_val("led1", 16'h0065, led_cfg.led1);
    check_val("led2", 16'h0065, led_cfg.led2);
    check_val("led3", 16'h0065, {8'h00, led_cfg.led3});
    check_val("led4", 16'h0065, {8'h00, led_cfg.led4});
    check_val("sw pins", 16'h0003, {14'h0000, sw1, sw0});
    check_val("sda pins", 16'h0002, {14'h0000, sda_oe_n, sda_out});
    for (int i = 0; i < 7; i++) begin
      rd_reg(reg_addr[i], d);
      check_val("reset read", {8'h00, reg_rst[i]}, {8'h00, d});
    end
    // Data lands at the data ack, before the Stop.
    mst.start_cond();
    mst.byte_xfer({cfg_ctrl_code, 3'h0, 1'b0}, 1'b1, d, ack);
    mst.byte_xfer(`REG_LED3, 1'b1, d, ack);
    mst.byte_xfer(8'h5a, 1'b1, d, ack);
    check_val("commit at ack", 16'h005a, {8'h00, led_cfg.led3});
    mst.stop_cond();
    for (int i = 0; i < 7; i++) begin
      wr_reg(cfg_ctrl_code, 3'h0, reg_addr[i], wr_val[i], 1'b0);
      rd_reg(reg_addr[i], d);
      check_val("readback", {8'h00, rd_exp[i]}, {8'h00, d});
    end
    check_val("led1 pair", 16'h4433, led_cfg.led1);
    check_val("led2 pair", 16'h6655, led_cfg.led2);
    check_val("sw pins fe", 16'h0001, {14'h0000, sw1, sw0});
    wr_reg(cfg_ctrl_code, 3'h0, `REG_SWITCH, 8'h01, 1'b0);
    check_val("sw pins 01", 16'h0002, {14'h0000, sw1, sw0});
    // A frozen port misses a whole write and never answers it.
    ce = 1'b0;
    wr_reg(cfg_ctrl_code, 3'h0, `REG_LED3, 8'h99, 1'b1);
    ce = 1'b1;
    check_val("led3 frozen", 16'h0011, {8'h00, led_cfg.led3});
    // Wrong control code: no ack and no effect.
    wr_reg(4'h5, 3'h0, `REG_LED3, 8'h99, 1'b1);
    check_val("led3 wrong code", 16'h0011, {8'h00, led_cfg.led3});
    // Non-zero block bits address an unmapped block.
    wr_reg(cfg_ctrl_code, 3'h1, `REG_LED3, 8'h77, 1'b0);
    check_val("led3 other block", 16'h0011, {8'h00, led_cfg.led3});
    // A new configured code is honoured.
    cfg_ctrl_code = 4'ha;
    wr_reg(4'ha, 3'h0, `REG_LED4, 8'hc3, 1'b0);
    check_val("led4 new code", 16'h00c3, {8'h00, led_cfg.led4});
    wr_reg(4'h3, 3'h0, `REG_LED4, 8'h3c, 1'b1);
    check_val("led4 old code", 16'h00c3, {8'h00, led_cfg.led4});
    // Current address read continues from the pointer left at C6.
    rd_reg(`REG_LED1_LO, d);
    mst.start_cond();
    mst.byte_xfer({cfg_ctrl_code, 3'h0, 1'b1}, 1'b1, d, ack);
    check_val("cur read ack", 16'h0000, {15'h0000, ack});
    // The master acknowledges the first byte, so C7 follows.
    mst.byte_xfer(8'hff, 1'b0, d, ack);
    check_val("cur read", 16'h0044, {8'h00, d});
    mst.byte_xfer(8'hff, 1'b1, d, ack);
    check_val("next read", 16'h0055, {8'h00, d});
    mst.stop_cond();
    // A reset in mid-run brings the defaults back.
    nrst = 1'b0;
    mst.tick(2);
    nrst = 1'b1;
    mst.tick(5);
    check_val("led1 rst again", 16'h0065, led_cfg.led1);
    check_val("led2 rst again", 16'h0065, led_cfg.led2);
    check_val("led4 rst again", 16'h0065, {8'h00, led_cfg.led4});
    check_val("sw rst again", 16'h0003, {14'h0000, sw1, sw0});
    rd_reg(`REG_LED3, d);
    check_val("led3 rst again", 16'h0065, {8'h00, d});
    close_out();
  end

endmodule
